// ==== logic/uirq_params.svh ====
// Register offsets, field positions and reset values of the UART interrupt slice
`ifndef UIRQ_PARAMS_SVH
`define UIRQ_PARAMS_SVH

`define UIRQ_OFF_LEVEL 12'h034
`define UIRQ_OFF_MASK 12'h038
`define UIRQ_OFF_RAW 12'h03C
`define UIRQ_OFF_MASKED 12'h040
`define UIRQ_OFF_CLEAR 12'h044

`define UIRQ_TXSEL_LSB 0
`define UIRQ_TXSEL_MSB 2
`define UIRQ_RXSEL_LSB 3
`define UIRQ_RXSEL_MSB 5
`define UIRQ_LEVEL_W 6
`define UIRQ_LEVEL_RST 6'h12

`define UIRQ_SRC_W 13
`define UIRQ_SRC_MSB 12
`define UIRQ_MASK_RST 13'h0000
`define UIRQ_SRC_IMPL 13'h1FF2

`define UIRQ_B_CTS 1
`define UIRQ_B_RX 4
`define UIRQ_B_TX 5
`define UIRQ_B_RT 6
`define UIRQ_B_FE 7
`define UIRQ_B_PE 8
`define UIRQ_B_BE 9
`define UIRQ_B_OE 10
`define UIRQ_B_XOFF 11
`define UIRQ_B_TXFE 12

`endif

// ==== logic/uirq_pkg.sv ====
// Types shared by the UART interrupt slice
package uirq_pkg;
    typedef logic [2:0] uirq_sel_t;
    typedef logic [12:0] uirq_src_t;
    typedef logic [31:0] uirq_word_t;
    typedef enum logic [2:0] {
        UIRQ_T64 = 3'h0,
        UIRQ_T32 = 3'h1,
        UIRQ_T16 = 3'h2,
        UIRQ_T8 = 3'h3,
        UIRQ_T4 = 3'h4,
        UIRQ_T2 = 3'h5,
        UIRQ_T34 = 3'h6
    } uirq_trig_t;
endpackage

// ==== logic/uirq_lvl_if.sv ====
// Trigger selector, FIFO count and level hit between the top and a level checker
`timescale 1ns/1ps
interface uirq_lvl_if #(parameter int CW = 7);
    logic [2:0] sel;
    logic [CW-1:0] count;
    logic hit;
    modport checker_end (input sel, input count, output hit);
    modport ctrl_end (output sel, output count, input hit);
endinterface

// ==== logic/uirq_level.sv ====
// FIFO trigger-level checker: compares a fill or free count with a selected fraction
`timescale 1ns/1ps
module uirq_level #(
    parameter int DEPTH = 64,
    parameter int CW = 7
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Selector, count and hit
    uirq_lvl_if.checker_end lvl
);
    import uirq_pkg::*;

    function automatic logic [CW-1:0] thresh(input logic [2:0] code);
        logic [CW-1:0] d;
        logic [CW-1:0] t;
        d = CW'(DEPTH);
        case (code)
            UIRQ_T64: t = d >> 6;
            UIRQ_T32: t = d >> 5;
            UIRQ_T16: t = d >> 4;
            UIRQ_T8: t = d >> 3;
            UIRQ_T4: t = d >> 2;
            UIRQ_T2: t = d >> 1;
            default: t = d - (d >> 2);
        endcase
        // A shallow FIFO must still trigger at one entry
        if (t == '0) begin
            t = CW'(1);
        end
        return t;
    endfunction

    logic [CW-1:0] limit;
    logic at_level;

    assign limit = thresh(lvl.sel);
    assign at_level = (lvl.count >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl.hit <= 1'b0;
        end else begin
            lvl.hit <= at_level;
        end
    end
endmodule

// ==== logic/uirq_top.sv ====
// UART interrupt slice: trigger levels, enable mask, sticky status and clear over APB
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "uirq_params.svh"

module uirq_top #(
    parameter int DEPTH = 64,
    parameter int CW = 7
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire uirq_pkg::uirq_word_t pwdata,
    output uirq_pkg::uirq_word_t prdata,
    output logic pready,
    output logic pslverr,
    // FIFO fill counts
    input wire logic [CW-1:0] tx_fill,
    input wire logic [CW-1:0] rx_fill,
    // Source events, one-cycle pulses
    input wire logic cts_change_event,
    input wire logic rx_timeout_event,
    input wire logic framing_err_event,
    input wire logic parity_err_event,
    input wire logic break_err_event,
    input wire logic overrun_err_event,
    input wire logic flow_stop_event,
    input wire logic tx_empty_event,
    // Trigger selectors for the FIFO logic
    output uirq_pkg::uirq_sel_t tx_fifo_trigger_select,
    output uirq_pkg::uirq_sel_t rx_fifo_trigger_select,
    // Combined interrupt
    output logic irq
);
    import uirq_pkg::*;

    logic [`UIRQ_LEVEL_W-1:0] level_sel;
    uirq_src_t interrupt_enable_mask;
    uirq_src_t raw_status;
    uirq_src_t masked_status;
    uirq_src_t set_vec;
    uirq_src_t clr_vec;
    uirq_src_t next_status;
    logic tx_hit_q;
    logic rx_hit_q;
    logic tx_rise;
    logic rx_rise;

    // APB decode
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire hit_level = (paddr == `UIRQ_OFF_LEVEL);
    wire hit_mask = (paddr == `UIRQ_OFF_MASK);
    wire hit_raw = (paddr == `UIRQ_OFF_RAW);
    wire hit_masked = (paddr == `UIRQ_OFF_MASKED);
    wire hit_clear = (paddr == `UIRQ_OFF_CLEAR);
    wire mapped = hit_level | hit_mask | hit_raw | hit_masked | hit_clear;
    wire wr_en = access_ph & pwrite & mapped;
    wire wr_level = wr_en & hit_level;
    wire wr_mask = wr_en & hit_mask;
    wire wr_clear = wr_en & hit_clear;

    // Zero wait states; only unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;

    // Read mux; the clear register reads zero since it is write-only
    wire [31:0] rd_level = {26'h0000000, level_sel};
    wire [31:0] rd_mask = {19'h00000, interrupt_enable_mask};
    wire [31:0] rd_raw = {19'h00000, raw_status};
    wire [31:0] rd_masked = {19'h00000, masked_status};
    wire [31:0] rd_mux = hit_level ? rd_level :
                         hit_mask ? rd_mask :
                         hit_raw ? rd_raw :
                         hit_masked ? rd_masked : 32'h00000000;

    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Level select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_sel <= `UIRQ_LEVEL_RST;
        end else if (wr_level) begin
            level_sel <= pwdata[`UIRQ_LEVEL_W-1:0];
        end
    end

    assign tx_fifo_trigger_select = level_sel[`UIRQ_TXSEL_MSB:`UIRQ_TXSEL_LSB];
    assign rx_fifo_trigger_select = level_sel[`UIRQ_RXSEL_MSB:`UIRQ_RXSEL_LSB];

    // Mask register; reserved bits are not stored and read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_enable_mask <= `UIRQ_MASK_RST;
        end else if (wr_mask) begin
            interrupt_enable_mask <= pwdata[`UIRQ_SRC_MSB:0] & `UIRQ_SRC_IMPL;
        end
    end

    // Level checkers
    uirq_lvl_if #(.CW(CW)) tx_lvl ();
    uirq_lvl_if #(.CW(CW)) rx_lvl ();

    // TX compares free space, RX compares fill
    assign tx_lvl.sel = tx_fifo_trigger_select;
    assign tx_lvl.count = CW'(DEPTH) - tx_fill;
    assign rx_lvl.sel = rx_fifo_trigger_select;
    assign rx_lvl.count = rx_fill;

    uirq_level #(.DEPTH(DEPTH), .CW(CW)) u_tx_level (
        .pclk(pclk),
        .presetn(presetn),
        .lvl(tx_lvl.checker_end)
    );

    uirq_level #(.DEPTH(DEPTH), .CW(CW)) u_rx_level (
        .pclk(pclk),
        .presetn(presetn),
        .lvl(rx_lvl.checker_end)
    );

    // Level interrupts fire on crossing, so a clear holds while the FIFO stays put
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_hit_q <= 1'b0;
            rx_hit_q <= 1'b0;
        end else begin
            tx_hit_q <= tx_lvl.hit;
            rx_hit_q <= rx_lvl.hit;
        end
    end

    assign tx_rise = tx_lvl.hit & ~tx_hit_q;
    assign rx_rise = rx_lvl.hit & ~rx_hit_q;

    // Source events mapped onto status bit positions
    always_comb begin
        set_vec = '0;
        set_vec[`UIRQ_B_CTS] = cts_change_event;
        set_vec[`UIRQ_B_RX] = rx_rise;
        set_vec[`UIRQ_B_TX] = tx_rise;
        set_vec[`UIRQ_B_RT] = rx_timeout_event;
        set_vec[`UIRQ_B_FE] = framing_err_event;
        set_vec[`UIRQ_B_PE] = parity_err_event;
        set_vec[`UIRQ_B_BE] = break_err_event;
        set_vec[`UIRQ_B_OE] = overrun_err_event;
        set_vec[`UIRQ_B_XOFF] = flow_stop_event;
        set_vec[`UIRQ_B_TXFE] = tx_empty_event;
    end

    // A one clears, a zero leaves the bit alone; a new event beats the clear
    assign clr_vec = wr_clear ? pwdata[`UIRQ_SRC_MSB:0] : '0;
    assign next_status = ((raw_status & ~clr_vec) | set_vec) & `UIRQ_SRC_IMPL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_status <= '0;
        end else begin
            raw_status <= next_status;
        end
    end

    assign masked_status = raw_status & interrupt_enable_mask;
    assign irq = |masked_status;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_mask_write: assert property (
        wr_mask |=> interrupt_enable_mask == ($past(pwdata[`UIRQ_SRC_MSB:0]) & `UIRQ_SRC_IMPL)
    ) else $error("mask register did not take the written value");

    a_mask_readback: assert property (
        (setup_ph && !pwrite && hit_mask) ##1 access_ph
        |-> prdata == {19'h00000, interrupt_enable_mask}
    ) else $error("mask read did not return the programmed enables");

    a_level_write: assert property (
        wr_level |=> tx_fifo_trigger_select == $past(pwdata[`UIRQ_TXSEL_MSB:`UIRQ_TXSEL_LSB])
            && rx_fifo_trigger_select == $past(pwdata[`UIRQ_RXSEL_MSB:`UIRQ_RXSEL_LSB])
    ) else $error("level selectors did not take the written value");

    a_level_read: assert property (
        (setup_ph && !pwrite && hit_level) |=> prdata[31:6] == 26'h0000000
            && prdata[5:0] == $past(level_sel)
    ) else $error("level register read wrong or reserved bits set");

    a_reserved_bits: assert property (
        (interrupt_enable_mask & ~`UIRQ_SRC_IMPL) == '0
            && (raw_status & ~`UIRQ_SRC_IMPL) == '0
    ) else $error("reserved mask or status bit is set");

    a_tx_level_set: assert property (
        $rose(tx_lvl.hit) |=> raw_status[`UIRQ_B_TX]
    ) else $error("tx level crossing did not set its status");

    a_rx_level_set: assert property (
        $rose(rx_lvl.hit) |=> raw_status[`UIRQ_B_RX]
    ) else $error("rx level crossing did not set its status");

    a_rx_level_cause: assert property (
        $rose(rx_lvl.hit) |-> $past(rx_fill) != '0
    ) else $error("rx level hit with an empty fifo");

    a_event_wins: assert property (
        (set_vec != '0) |=> (raw_status & $past(set_vec & `UIRQ_SRC_IMPL))
            == $past(set_vec & `UIRQ_SRC_IMPL)
    ) else $error("an event was lost against a clear");

    a_clear_effect: assert property (
        wr_clear |=> (raw_status & $past(pwdata[`UIRQ_SRC_MSB:0]) & ~$past(set_vec)) == '0
    ) else $error("write of one to clear left a bit pending");

    a_clear_zero_keeps: assert property (
        (wr_clear && pwdata[`UIRQ_SRC_MSB:0] == '0) |=> (raw_status & $past(raw_status))
            == $past(raw_status)
    ) else $error("write of zero to clear changed status");

    a_masked_gate: assert property (
        masked_status[`UIRQ_B_TXFE] |-> raw_status[`UIRQ_B_TXFE]
            && interrupt_enable_mask[`UIRQ_B_TXFE]
    ) else $error("masked status set without pending and enabled");

    a_irq_follows: assert property (
        (tx_empty_event && interrupt_enable_mask[`UIRQ_B_TXFE] && !wr_mask) |=> irq
    ) else $error("enabled event did not raise the interrupt");

    a_irq_quiet: assert property (
        (interrupt_enable_mask == '0) |-> !irq
    ) else $error("interrupt high with every source disabled");

    a_cts_enabled: assert property (
        (cts_change_event && interrupt_enable_mask[`UIRQ_B_CTS] && !wr_mask)
            |=> masked_status[`UIRQ_B_CTS]
    ) else $error("enabled clear-to-send change not reported");

    a_rx_enabled: assert property (
        ($rose(rx_lvl.hit) && interrupt_enable_mask[`UIRQ_B_RX] && !wr_mask)
            |=> masked_status[`UIRQ_B_RX]
    ) else $error("enabled rx level crossing not reported");

    a_tx_enabled: assert property (
        ($rose(tx_lvl.hit) && interrupt_enable_mask[`UIRQ_B_TX] && !wr_mask)
            |=> masked_status[`UIRQ_B_TX]
    ) else $error("enabled tx level crossing not reported");

    a_rt_enabled: assert property (
        (rx_timeout_event && interrupt_enable_mask[`UIRQ_B_RT] && !wr_mask)
            |=> masked_status[`UIRQ_B_RT]
    ) else $error("enabled rx timeout not reported");

    a_fe_enabled: assert property (
        (framing_err_event && interrupt_enable_mask[`UIRQ_B_FE] && !wr_mask)
            |=> masked_status[`UIRQ_B_FE]
    ) else $error("enabled framing error not reported");

    a_pe_enabled: assert property (
        (parity_err_event && interrupt_enable_mask[`UIRQ_B_PE] && !wr_mask)
            |=> masked_status[`UIRQ_B_PE]
    ) else $error("enabled parity error not reported");

    a_be_enabled: assert property (
        (break_err_event && interrupt_enable_mask[`UIRQ_B_BE] && !wr_mask)
            |=> masked_status[`UIRQ_B_BE]
    ) else $error("enabled break error not reported");

    a_oe_enabled: assert property (
        (overrun_err_event && interrupt_enable_mask[`UIRQ_B_OE] && !wr_mask)
            |=> masked_status[`UIRQ_B_OE]
    ) else $error("enabled overrun error not reported");

    a_flow_enabled: assert property (
        (flow_stop_event && interrupt_enable_mask[`UIRQ_B_XOFF] && !wr_mask)
            |=> masked_status[`UIRQ_B_XOFF]
    ) else $error("enabled flow stop not reported");

    a_tx_level_cause: assert property (
        $rose(tx_lvl.hit) |-> $past(tx_fill) != CW'(DEPTH)
    ) else $error("tx level hit with a full fifo");

    a_tx_half_hit: assert property (
        (tx_fifo_trigger_select == UIRQ_T2 && (CW'(DEPTH) - tx_fill) >= CW'(DEPTH / 2))
            |=> tx_lvl.hit
    ) else $error("tx fifo half empty without a level hit");

    a_tx_half_miss: assert property (
        (tx_fifo_trigger_select == UIRQ_T2 && (CW'(DEPTH) - tx_fill) < CW'(DEPTH / 2))
            |=> !tx_lvl.hit
    ) else $error("tx level hit below half empty");

    a_rx_half_hit: assert property (
        (rx_fifo_trigger_select == UIRQ_T2 && rx_fill >= CW'(DEPTH / 2))
            |=> rx_lvl.hit
    ) else $error("rx fifo half full without a level hit");

    a_rx_half_miss: assert property (
        (rx_fifo_trigger_select == UIRQ_T2 && rx_fill < CW'(DEPTH / 2))
            |=> !rx_lvl.hit
    ) else $error("rx level hit below half full");

    a_unmapped_no_write: assert property (
        (access_ph && pwrite && !mapped)
            |=> $stable(interrupt_enable_mask) && $stable(level_sel)
    ) else $error("write to an unmapped address changed a register");

    a_mask_holds: assert property (
        !wr_mask |=> $stable(interrupt_enable_mask)
    ) else $error("mask changed without a mask write");

    a_no_spurious_set: assert property (
        (raw_status & ~$past(raw_status) & ~$past(set_vec)) == '0
    ) else $error("status bit set without its event");

    a_clear_only_falls: assert property (
        ($past(raw_status) & ~raw_status & ~$past(clr_vec)) == '0
    ) else $error("status bit fell without a clear");

    a_masked_read: assert property (
        (setup_ph && !pwrite && hit_masked)
            |=> prdata == {19'h00000, $past(raw_status & interrupt_enable_mask)}
    ) else $error("masked status read did not match pending and enabled");

    c_irq_rise: cover property ($rose(irq));
    c_set_and_clear: cover property (wr_clear && (set_vec & pwdata[`UIRQ_SRC_MSB:0]) != '0);
    c_unmapped: cover property (pslverr);
    c_tx_level: cover property ($rose(tx_lvl.hit) && tx_fifo_trigger_select == UIRQ_T34);
    c_masked_event: cover property (tx_empty_event && interrupt_enable_mask[`UIRQ_B_TXFE]);
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the UART interrupt slice
`timescale 1ns/1ps
`include "uirq_params.svh"

module tb_top;
    import uirq_pkg::*;
    localparam int DEPTH = 64;
    localparam int CW = 7;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    uirq_word_t pwdata = 32'h0;
    uirq_word_t prdata;
    logic pready;
    logic pslverr;
    // Full TX FIFO and empty RX FIFO keep both level hits low after reset
    logic [CW-1:0] tx_fill = CW'(DEPTH);
    logic [CW-1:0] rx_fill = '0;
    logic [7:0] ev = 8'h00;
    uirq_sel_t tx_sel;
    uirq_sel_t rx_sel;
    logic irq;
    int miscompares = 0;
    int checks_done = 0;
    logic [32:0] expq[$];
    int src_bit[8] = '{1, 6, 7, 8, 9, 10, 11, 12};

    always #50 pclk = ~pclk;

    uirq_top #(.DEPTH(DEPTH), .CW(CW)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_fill(tx_fill), .rx_fill(rx_fill), .cts_change_event(ev[0]),
        .rx_timeout_event(ev[1]), .framing_err_event(ev[2]), .parity_err_event(ev[3]),
        .break_err_event(ev[4]), .overrun_err_event(ev[5]), .flow_stop_event(ev[6]),
        .tx_empty_event(ev[7]), .tx_fifo_trigger_select(tx_sel),
        .rx_fifo_trigger_select(rx_sel), .irq(irq)
    );

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err = 1'b0);
        expq.push_back({err, exp});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        ev <= 8'(8'h01 << i);
        @(posedge pclk);
        ev <= 8'h00;
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge pclk);
        cmp("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    // Read data is taken at the completing edge, oldest note first
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() == 0) begin
                cmp("unexpected read", 32'h0, 32'h1);
            end else begin
                cmp("prdata", expq[0][31:0], prdata);
                cmp("pslverr", {31'h0, expq[0][32]}, {31'h0, pslverr});
                void'(expq.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        summarize();
    end

    initial begin
        logic [31:0] r;
        logic [31:0] b;
        int thr;
        void'($urandom(11));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        cmp("tx select", 32'h2, {29'h0, tx_sel});
        cmp("rx select", 32'h2, {29'h0, rx_sel});
        cmp("pready", 32'h1, {31'h0, pready});
        rd(`UIRQ_OFF_LEVEL, 32'h12);
        rd(`UIRQ_OFF_MASK, 32'h0);
        rd(12'h100, 32'h0, 1'b1);
        wr(12'h100, 32'hFFFFFFFF);
        rd(`UIRQ_OFF_MASK, 32'h0);
        wr(`UIRQ_OFF_RAW, 32'hFFFFFFFF);
        rd(`UIRQ_OFF_RAW, 32'h0);
        rd(`UIRQ_OFF_CLEAR, 32'h0);
        for (int k = 0; k < 4; k++) begin
            r = (k == 0) ? 32'hFFFFFFFF : $urandom();
            wr(`UIRQ_OFF_LEVEL, r);
            rd(`UIRQ_OFF_LEVEL, r & 32'h3F);
            cmp("tx select", {29'h0, r[2:0]}, {29'h0, tx_sel});
            cmp("rx select", {29'h0, r[5:3]}, {29'h0, rx_sel});
            wr(`UIRQ_OFF_MASK, r);
            rd(`UIRQ_OFF_MASK, r & 32'h1FF2);
        end
        wr(`UIRQ_OFF_MASK, 32'h0);
        for (int i = 0; i < 8; i++) begin
            b = 32'h1 << src_bit[i];
            pulse(i);
            chk_irq(1'b0);
            rd(`UIRQ_OFF_RAW, b);
            rd(`UIRQ_OFF_MASKED, 32'h0);
            wr(`UIRQ_OFF_MASK, b);
            chk_irq(1'b1);
            rd(`UIRQ_OFF_MASKED, b);
            wr(`UIRQ_OFF_CLEAR, ~b);
            rd(`UIRQ_OFF_RAW, b);
            wr(`UIRQ_OFF_CLEAR, b);
            chk_irq(1'b0);
            rd(`UIRQ_OFF_RAW, 32'h0);
            pulse(i);
            chk_irq(1'b1);
            wr(`UIRQ_OFF_CLEAR, b);
            wr(`UIRQ_OFF_MASK, 32'h0);
        end
        // An event on the clearing edge must survive the clear
        fork
            wr(`UIRQ_OFF_CLEAR, 32'h1000);
            begin
                repeat (2) @(posedge pclk);
                ev <= 8'h80;
                @(posedge pclk);
                ev <= 8'h00;
            end
        join
        rd(`UIRQ_OFF_RAW, 32'h1000);
        wr(`UIRQ_OFF_CLEAR, 32'h1000);
        rd(`UIRQ_OFF_RAW, 32'h0);
        // Each code is probed one entry short of its threshold, then exactly on it
        wr(`UIRQ_OFF_MASK, 32'h30);
        for (int c = 0; c < 8; c++) begin
            thr = (c >= 6) ? 48 : (DEPTH >> (6 - c));
            wr(`UIRQ_OFF_LEVEL, 32'(c * 9));
            rx_fill <= CW'(thr - 1);
            tx_fill <= CW'(DEPTH + 1 - thr);
            repeat (4) @(posedge pclk);
            wr(`UIRQ_OFF_CLEAR, 32'h30);
            chk_irq(1'b0);
            rd(`UIRQ_OFF_RAW, 32'h0);
            rx_fill <= CW'(thr);
            tx_fill <= CW'(DEPTH - thr);
            repeat (4) @(posedge pclk);
            rd(`UIRQ_OFF_RAW, 32'h30);
            chk_irq(1'b1);
            wr(`UIRQ_OFF_CLEAR, 32'h10);
            rd(`UIRQ_OFF_MASKED, 32'h20);
            wr(`UIRQ_OFF_CLEAR, 32'h20);
            chk_irq(1'b0);
        end
        repeat (2) @(posedge pclk);
        cmp("pending notes", 32'h0, 32'(expq.size()));
        summarize();
    end
endmodule
